// *** logic/intc_defs.svh ***
// Address map, reset values and field codes of the interrupt flag registers
`ifndef INTC_DEFS_SVH
`define INTC_DEFS_SVH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define ADDR_REQ0L 16'hFFE0
`define ADDR_REQ0H 16'hFFE1
`define ADDR_REQ1L 16'hFFE2
`define ADDR_MASK0L 16'hFFE4
`define ADDR_MASK0H 16'hFFE5
`define ADDR_MASK1L 16'hFFE6
`define ADDR_PRIO0L 16'hFFE8
`define ADDR_PRIO0H 16'hFFE9
`define ADDR_PRIO1L 16'hFFEA
`define ADDR_EDGE0 16'hFFEC
`define ADDR_EDGE1 16'hFFED

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_REQ 8'h00
`define RST_MASK 8'hFF
`define RST_PRIO 8'hFF
`define RST_EDGE 8'h00

// ----------------------------------------
// Field positions and codes
// ----------------------------------------
`define NUM_SRC 19
`define SRC_WDT 0
`define BIT_TEST 7
`define EDGE_FALL 2'h0
`define EDGE_RISE 2'h1
`define EDGE_BOTH 2'h3

`endif

// *** logic/intc_pkg.sv ***
// Types shared by the interrupt flag register block
package intc_pkg;
    // Width of one CPU memory access
    typedef enum logic [1:0] {
        ACC_BIT,
        ACC_BYTE,
        ACC_WORD
    } access_width_t;
endpackage : intc_pkg

// *** logic/pin_edge_detect.sv ***
// Synchronised edge detection for the external interrupt pins
`timescale 1ns/1ns
`include "intc_defs.svh"
module pin_edge_detect #(
    parameter int NPINS = 7
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // Pins and 2-bit edge codes, pin 0 in the low bits
    input wire logic [NPINS-1:0] i_pin,
    input wire logic [2*NPINS-1:0] i_edge_sel,
    // One-cycle event per pin
    output logic [NPINS-1:0] o_event
);
    logic [NPINS-1:0] sync1; // First stage, read only by sync2
    logic [NPINS-1:0] sync2; // Second stage
    logic [NPINS-1:0] prev; // Last synchronised level
    logic [NPINS-1:0] next_sync1;
    logic [NPINS-1:0] next_sync2;
    logic [NPINS-1:0] next_prev;
    logic [NPINS-1:0] next_event;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        next_sync1 = i_pin;
        next_sync2 = sync1;
        next_prev = sync2;
        for (int p = 0; p < NPINS; p++) begin
            // Prohibited code 10 detects nothing rather than guessing
            unique case (i_edge_sel[2*p +: 2])
                `EDGE_FALL: next_event[p] = prev[p] & ~sync2[p];
                `EDGE_RISE: next_event[p] = ~prev[p] & sync2[p];
                `EDGE_BOTH: next_event[p] = prev[p] ^ sync2[p];
                default: next_event[p] = 1'b0;
            endcase
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            sync1 <= '0;
            sync2 <= '0;
            prev <= '0;
            o_event <= '0;
        end else begin
            sync1 <= next_sync1;
            sync2 <= next_sync2;
            prev <= next_prev;
            o_event <= next_event;
        end
    end
endmodule : pin_edge_detect

// *** logic/interrupt_flag_control_regs.sv ***
// Request, mask, priority and edge-mode registers of the interrupt unit
`timescale 1ns/1ns
`include "intc_defs.svh"
module interrupt_flag_control_regs
    import intc_pkg::*;
(
    // Clock and reset
    input wire logic I_CLK,
    input wire logic I_RESET,
    // CPU memory access
    input wire logic [15:0] I_ADDR,
    input wire logic I_WR,
    input wire logic I_RD,
    input wire access_width_t I_WIDTH,
    input wire logic [2:0] I_BIT,
    input wire logic [15:0] I_WDATA,
    output logic [15:0] O_RDATA,
    // Interrupt sources
    input wire logic [6:0] I_PIN,
    input wire logic I_WDT_OVF,
    input wire logic I_WDT_INTERVAL,
    input wire logic [10:0] I_INT_SRC,
    input wire logic I_3W_CH2_DONE,
    input wire logic I_TEST_EVT,
    // Acknowledge from the CPU core
    input wire logic I_ACK,
    input wire logic [4:0] I_ACK_ID,
    // Request towards the CPU core
    output logic O_IRQ_VALID,
    output logic [4:0] O_IRQ_ID,
    output logic O_IRQ_LOW,
    output logic O_STANDBY_RELEASE
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [`NUM_SRC-1:0] req; // Request flags, default order
    logic req_test; // Test input flag
    logic [`NUM_SRC-1:0] mask; // Mask flags
    logic mask_test; // Test input standby mask
    logic [`NUM_SRC-1:0] prio; // Priority flags, 1 = low group
    logic [7:0] edge0; // Pins 0-2 edge modes in bits 7:2
    logic [7:0] edge1; // Pins 3-6 edge modes
    logic [`NUM_SRC-1:0] next_req;
    logic next_req_test;
    logic [`NUM_SRC-1:0] next_mask;
    logic next_mask_test;
    logic [`NUM_SRC-1:0] next_prio;
    logic [7:0] next_edge0;
    logic [7:0] next_edge1;
    logic [15:0] next_rdata;
    logic next_irq_valid;
    logic [4:0] next_irq_id;
    logic next_irq_low;
    logic next_standby;

    // Byte images as software sees them
    logic [7:0] req_img [3];
    logic [7:0] mask_img [3];
    logic [7:0] prio_img [3];
    logic [7:0] nreq [3];
    logic [7:0] nmask [3];
    logic [7:0] nprio [3];

    // Events from the sources
    logic [6:0] pin_evt; // Pin edges after synchronisation
    logic [`NUM_SRC-1:0] src_set; // Set requests per flag
    logic [`NUM_SRC-1:0] elig; // Request and not masked
    logic [`NUM_SRC-1:0] elig_high; // Eligible in high group

    // ----------------------------------------
    // Pin edge detection
    // ----------------------------------------
    pin_edge_detect #(
        .NPINS(7)
    ) u_edges (
        .i_clk(I_CLK),
        .i_reset(I_RESET),
        .i_pin(I_PIN),
        .i_edge_sel({edge1, edge0[7:2]}),
        .o_event(pin_evt)
    );

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // New value of one byte register after the current access
    function automatic logic [7:0] wr_byte(input logic [7:0] cur, input logic [15:0] a,
                                           input logic bit_ok, input logic word_ok);
        logic [7:0] r;
        r = cur;
        if (I_WR) begin
            unique case (I_WIDTH)
                ACC_BIT: begin
                    if (bit_ok && I_ADDR == a) begin
                        r[I_BIT] = I_WDATA[0];
                    end
                end
                ACC_BYTE: begin
                    if (I_ADDR == a) begin
                        r = I_WDATA[7:0];
                    end
                end
                ACC_WORD: begin
                    // Word pairs sit at even addresses, low byte first
                    if (word_ok && {I_ADDR[15:1], 1'b0} == a) begin
                        r = I_WDATA[7:0];
                    end else if (word_ok && {I_ADDR[15:1], 1'b1} == a) begin
                        r = I_WDATA[15:8];
                    end
                end
                default: r = cur;
            endcase
        end
        return r;
    endfunction : wr_byte

    // Lowest set index, which is the highest default priority
    // Plain scan: a long chain, but short enough for one cycle at this clock
    function automatic logic [4:0] first_set(input logic [`NUM_SRC-1:0] v);
        logic [4:0] idx;
        idx = 5'h00;
        for (int i = `NUM_SRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                idx = 5'(i);
            end
        end
        return idx;
    endfunction : first_set

    // Read value of one byte address, zero when unmapped
    function automatic logic [7:0] rd_byte(input logic [15:0] a);
        logic [7:0] r;
        unique case (a)
            `ADDR_REQ0L: r = req_img[0];
            `ADDR_REQ0H: r = req_img[1];
            `ADDR_REQ1L: r = req_img[2];
            // Watchdog mask returns its stored bit in watchdog mode 1
            `ADDR_MASK0L: r = mask_img[0];
            `ADDR_MASK0H: r = mask_img[1];
            `ADDR_MASK1L: r = mask_img[2];
            `ADDR_PRIO0L: r = prio_img[0];
            `ADDR_PRIO0H: r = prio_img[1];
            `ADDR_PRIO1L: r = prio_img[2];
            `ADDR_EDGE0: r = edge0;
            `ADDR_EDGE1: r = edge1;
            default: r = 8'h00;
        endcase
        return r;
    endfunction : rd_byte

    // ----------------------------------------
    // Byte images and source mapping
    // ----------------------------------------
    // Group 1 reserved bits read back as software must write them
    always_comb begin
        req_img[0] = req[7:0];
        req_img[1] = req[15:8];
        req_img[2] = {req_test, 4'h0, req[18:16]};
        mask_img[0] = mask[7:0];
        mask_img[1] = mask[15:8];
        mask_img[2] = {mask_test, 4'hF, mask[18:16]};
        prio_img[0] = prio[7:0];
        prio_img[1] = prio[15:8];
        prio_img[2] = {5'h1F, prio[18:16]};
        // Watchdog, pins 0-6, then serial, timers and converter
        src_set = {I_INT_SRC[10:4], I_INT_SRC[3] | I_3W_CH2_DONE, I_INT_SRC[2:0],
                   pin_evt, I_WDT_OVF & I_WDT_INTERVAL};
    end

    // ----------------------------------------
    // Flag registers, next values
    // ----------------------------------------
    always_comb begin
        nreq[0] = wr_byte(req_img[0], `ADDR_REQ0L, 1'b1, 1'b1);
        nreq[1] = wr_byte(req_img[1], `ADDR_REQ0H, 1'b1, 1'b1);
        nreq[2] = wr_byte(req_img[2], `ADDR_REQ1L, 1'b1, 1'b0);
        nmask[0] = wr_byte(mask_img[0], `ADDR_MASK0L, 1'b1, 1'b1);
        nmask[1] = wr_byte(mask_img[1], `ADDR_MASK0H, 1'b1, 1'b1);
        nmask[2] = wr_byte(mask_img[2], `ADDR_MASK1L, 1'b1, 1'b0);
        nprio[0] = wr_byte(prio_img[0], `ADDR_PRIO0L, 1'b1, 1'b1);
        nprio[1] = wr_byte(prio_img[1], `ADDR_PRIO0H, 1'b1, 1'b1);
        nprio[2] = wr_byte(prio_img[2], `ADDR_PRIO1L, 1'b1, 1'b0);
        // Edge registers ignore bit and word writes
        next_edge0 = wr_byte(edge0, `ADDR_EDGE0, 1'b0, 1'b0);
        next_edge1 = wr_byte(edge1, `ADDR_EDGE1, 1'b0, 1'b0);
        next_edge0[1:0] = 2'h0;
        // Software write first, a zero write clears
        next_req = {nreq[2][2:0], nreq[1], nreq[0]};
        next_req_test = nreq[2][`BIT_TEST];
        next_mask = {nmask[2][2:0], nmask[1], nmask[0]};
        next_mask_test = nmask[2][`BIT_TEST];
        next_prio = {nprio[2][2:0], nprio[1], nprio[0]};
        // Acknowledge clears the serviced flag
        // Ids above 18 are ignored so the index never leaves the vector
        if (I_ACK && I_ACK_ID < 5'(`NUM_SRC)) begin
            next_req[I_ACK_ID] = 1'b0;
        end
        // Watchdog flag held at zero outside interval mode
        if (!I_WDT_INTERVAL) begin
            next_req[`SRC_WDT] = 1'b0;
        end
        // Events set last so they win over any clear
        next_req = next_req | src_set;
        next_req_test = next_req_test | I_TEST_EVT;
    end

    // ----------------------------------------
    // Arbitration and read data, next values
    // ----------------------------------------
    always_comb begin
        elig = req & ~mask;
        elig_high = elig & ~prio;
        next_irq_valid = |elig;
        // High group first, then default order within the group
        if (|elig_high) begin
            next_irq_id = first_set(elig_high);
            next_irq_low = 1'b0;
        end else begin
            next_irq_id = first_set(elig);
            next_irq_low = |elig;
        end
        // Test flag only wakes from standby, never vectors
        next_standby = (|elig) | (req_test & ~mask_test);
        next_rdata = 16'h0000;
        if (I_RD) begin
            if (I_WIDTH == ACC_WORD) begin
                next_rdata = {rd_byte({I_ADDR[15:1], 1'b1}), rd_byte({I_ADDR[15:1], 1'b0})};
            end else begin
                next_rdata = {8'h00, rd_byte(I_ADDR)};
            end
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            // Group 1 reserved bits are not stored, only the live bits reset
            req <= {3'h0, `RST_REQ, `RST_REQ};
            req_test <= 1'b0;
            mask <= {3'h7, `RST_MASK, `RST_MASK};
            mask_test <= 1'b1;
            prio <= {3'h7, `RST_PRIO, `RST_PRIO};
            edge0 <= `RST_EDGE;
            edge1 <= `RST_EDGE;
            O_RDATA <= 16'h0000;
            O_IRQ_VALID <= 1'b0;
            O_IRQ_ID <= 5'h00;
            O_IRQ_LOW <= 1'b0;
            O_STANDBY_RELEASE <= 1'b0;
        end else begin
            req <= next_req;
            req_test <= next_req_test;
            mask <= next_mask;
            mask_test <= next_mask_test;
            prio <= next_prio;
            edge0 <= next_edge0;
            edge1 <= next_edge1;
            O_RDATA <= next_rdata;
            O_IRQ_VALID <= next_irq_valid;
            O_IRQ_ID <= next_irq_id;
            O_IRQ_LOW <= next_irq_low;
            O_STANDBY_RELEASE <= next_standby;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (I_RESET);

    // Write shapes seen on the CPU port
    sequence byte_wr_s(logic [15:0] a);
        I_WR && I_WIDTH == ACC_BYTE && I_ADDR == a;
    endsequence

    sequence word_wr_s(logic [15:0] a);
        I_WR && I_WIDTH == ACC_WORD && I_ADDR == a;
    endsequence

    reset_values_a: assert property ($fell(I_RESET) |->
        mask == '1 && prio == '1 && req == '0 && edge1 == 8'h00)
        else $error("Registers not at reset values");

    set_wins_a: assert property (src_set[4] |=> req[4])
        else $error("Pin event lost against a clear");

    ack_clear_a: assert property (I_ACK && I_ACK_ID == 5'd8 && !src_set[8] && !I_WR
        |=> !req[8])
        else $error("Acknowledge did not clear the flag");

    word_mask_a: assert property (word_wr_s(`ADDR_MASK0L) |=>
        mask[15:0] == $past(I_WDATA))
        else $error("Word write to mask pair lost");

    edge_byte_a: assert property (byte_wr_s(`ADDR_EDGE1) |=> edge1 == $past(I_WDATA[7:0]))
        else $error("Edge register byte write lost");

    edge_bit_a: assert property (I_WR && I_WIDTH != ACC_BYTE |=> $stable(edge1))
        else $error("Edge register changed on non-byte write");

    edge0_low_a: assert property (edge0[1:0] == 2'h0)
        else $error("Pin 0-2 edge register low bits not zero");

    wdt_mode_a: assert property (!I_WDT_INTERVAL |=> !req[`SRC_WDT])
        else $error("Watchdog flag set outside interval mode");

    // Index the past eligible vector with the id shown now, since the id is registered from that vector one cycle later
    irq_gate_a: assert property (O_IRQ_VALID |-> ($past(req & ~mask) & (19'h00001 << O_IRQ_ID)) != '0)
        else $error("Request raised for a masked or idle source");

    high_first_a: assert property (O_IRQ_VALID && O_IRQ_LOW |-> $past((req & ~mask & ~prio) == '0))
        else $error("Low group chosen over a high request");

    test_wake_a: assert property (req_test && !mask_test && (req & ~mask) == '0
        |=> O_STANDBY_RELEASE && !O_IRQ_VALID)
        else $error("Test flag wake or vector wrong");
endmodule : interrupt_flag_control_regs

// *** tb/event_source_model.sv ***
// Behavioural model of the peripheral event sources that feed the flag block
`timescale 1ns/1ns
module event_source_model (
    // Clock
    input wire logic i_clk,
    // Event pulses towards the flag block
    output logic [10:0] o_int_src,
    output logic o_3w_done,
    output logic o_test_evt,
    output logic o_wdt_ovf
);
    // ----------------------------------------
    // Pulse generation
    // ----------------------------------------
    // Quiet until a pulse is asked for
    initial {o_wdt_ovf, o_test_evt, o_3w_done, o_int_src} = 14'h0000;

    // One-cycle pulses launched off the falling edge, so the block sees a clean sample
    task automatic fire(input logic [13:0] ev);
        @(negedge i_clk);
        {o_wdt_ovf, o_test_evt, o_3w_done, o_int_src} = ev;
        @(negedge i_clk);
        {o_wdt_ovf, o_test_evt, o_3w_done, o_int_src} = 14'h0000;
    endtask : fire
endmodule : event_source_model

// *** tb/tb_interrupt_flag_control_regs.sv ***
// Self-checking bench for the interrupt flag register block
`timescale 1ns/1ns
`include "intc_defs.svh"
module tb_interrupt_flag_control_regs
    import intc_pkg::*;
();
    // ----------------------------------------
    // Bench signals
    // ----------------------------------------
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [15:0] addr = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    access_width_t width = ACC_BYTE;
    logic [2:0] bitn = 3'h0;
    logic [15:0] wdata = 16'h0000;
    logic [6:0] pin = 7'h00;
    logic wdt_int = 1'b1;
    logic ack = 1'b0;
    logic [4:0] ack_id = 5'h00;
    logic [15:0] rdata;
    logic irq_valid, irq_low, stby;
    logic [4:0] irq_id;
    logic [10:0] int_src;
    logic w3_done, test_evt, wdt_ovf;
    // Expected read data, oldest first
    logic [15:0] exp_q[$];
    logic pend = 1'b0;
    int errors = 0;
    int checks = 0;
    int seed = 50;
    logic [15:0] rnd;
    // Reset map: addresses and values, with one unmapped hole at the end
    logic [15:0] map_a [12] = '{`ADDR_REQ0L, `ADDR_REQ0H, `ADDR_REQ1L, `ADDR_MASK0L, `ADDR_MASK0H,
        `ADDR_MASK1L, `ADDR_PRIO0L, `ADDR_PRIO0H, `ADDR_PRIO1L, `ADDR_EDGE0, `ADDR_EDGE1, 16'hFFE3};
    logic [7:0] map_v [12] = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
        8'h00, 8'h00, 8'h00};

    // Free-running 100 MHz clock
    always #5 clk = ~clk;

    // ----------------------------------------
    // Design and source model
    // ----------------------------------------
    interrupt_flag_control_regs dut (.I_CLK(clk), .I_RESET(reset), .I_ADDR(addr), .I_WR(wr), .I_RD(rd),
        .I_WIDTH(width), .I_BIT(bitn), .I_WDATA(wdata), .O_RDATA(rdata), .I_PIN(pin), .I_WDT_OVF(wdt_ovf),
        .I_WDT_INTERVAL(wdt_int), .I_INT_SRC(int_src), .I_3W_CH2_DONE(w3_done), .I_TEST_EVT(test_evt),
        .I_ACK(ack), .I_ACK_ID(ack_id), .O_IRQ_VALID(irq_valid), .O_IRQ_ID(irq_id), .O_IRQ_LOW(irq_low),
        .O_STANDBY_RELEASE(stby));
    event_source_model src (.i_clk(clk), .o_int_src(int_src), .o_3w_done(w3_done), .o_test_evt(test_evt),
        .o_wdt_ovf(wdt_ovf));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    // Compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One write, strobe held for exactly one rising edge
    task automatic wr_reg(input logic [15:0] a, input access_width_t w, input logic [2:0] b, input logic [15:0] d);
        @(negedge clk);
        addr = a;
        width = w;
        bitn = b;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask : wr_reg

    // One read; the expectation is queued for the monitor
    task automatic rd_reg(input logic [15:0] a, input access_width_t w, input logic [15:0] exp);
        @(negedge clk);
        addr = a;
        width = w;
        rd = 1'b1;
        exp_q.push_back(exp);
        @(negedge clk);
        rd = 1'b0;
    endtask : rd_reg

    // Acknowledge pulse from the core
    task automatic ack_src(input logic [4:0] id);
        @(negedge clk);
        ack = 1'b1;
        ack_id = id;
        @(negedge clk);
        ack = 1'b0;
    endtask : ack_src

    // Counts and verdict, the single end of the run
    task automatic test_done;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done

    // ----------------------------------------
    // Read monitor
    // ----------------------------------------
    // Read data stands for the one cycle after the taking edge, so sample it mid-cycle
    always @(posedge clk) pend <= rd & ~reset;
    always @(negedge clk) begin
        if (pend && exp_q.size() == 0) begin
            errors++;
            $display("ERROR t=%0t read data with nothing expected", $time);
        end else if (pend) begin
            check(rdata, exp_q.pop_front());
        end
    end

    // Hang guard: bounded, counts as a mismatch
    initial begin
        repeat (20000) @(negedge clk);
        errors++;
        test_done();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (16) @(negedge clk);
        reset = 1'b0;
        // Reset values, unmapped hole reads zero
        for (int i = 0; i < 12; i++) rd_reg(map_a[i], ACC_BYTE, {8'h00, map_v[i]});
        $display("done: reset values");
        // Pins 3-6 edge register: byte access only
        wr_reg(`ADDR_EDGE1, ACC_BYTE, 3'h0, 16'h00C3);
        rd_reg(`ADDR_EDGE1, ACC_BYTE, 16'h00C3);
        wr_reg(`ADDR_EDGE1, ACC_BIT, 3'h0, 16'h0000);
        rd_reg(`ADDR_EDGE1, ACC_BYTE, 16'h00C3);
        wr_reg(`ADDR_EDGE1, ACC_BYTE, 3'h0, 16'h0000);
        // No 16-bit timer on this bench, so it already stands stopped before the pin 0 edge change
        wr_reg(`ADDR_EDGE0, ACC_BYTE, 3'h0, 16'h00FF);
        rd_reg(`ADDR_EDGE0, ACC_BYTE, 16'h00FC);
        wr_reg(`ADDR_EDGE0, ACC_BYTE, 3'h0, 16'h0000);
        $display("done: edge register access");
        // Random words through the three group-0 pairs, then restore defaults
        for (int i = 0; i < 3; i++) begin
            rnd = 16'($random(seed));
            wr_reg(map_a[3*i], ACC_WORD, 3'h0, rnd);
            // Odd address on the word read: bit 0 is ignored for word pairs
            rd_reg(map_a[3*i+1], ACC_WORD, rnd);
            rd_reg(map_a[3*i+1], ACC_BYTE, {8'h00, rnd[15:8]});
            wr_reg(map_a[3*i], ACC_WORD, 3'h0, i == 0 ? 16'h0000 : 16'hFFFF);
        end
        $display("done: word access");
        // Two sources in one cycle, unmasked by bit writes
        wr_reg(`ADDR_MASK0H, ACC_BIT, 3'h0, 16'h0000);
        wr_reg(`ADDR_MASK0H, ACC_BIT, 3'h1, 16'h0000);
        src.fire(14'h0003);
        @(negedge clk);
        check({15'h0000, irq_valid}, 16'h0001);
        check({11'h000, irq_id}, 16'h0008);
        check({15'h0000, irq_low}, 16'h0001);
        ack_src(5'h08);
        @(negedge clk);
        check({11'h000, irq_id}, 16'h0009);
        wr_reg(`ADDR_PRIO0H, ACC_BIT, 3'h1, 16'h0000);
        @(negedge clk);
        check({15'h0000, irq_low}, 16'h0000);
        ack_src(5'h09);
        @(negedge clk);
        check({15'h0000, irq_valid}, 16'h0000);
        // A masked source pends but is not offered
        src.fire(14'h0004);
        @(negedge clk);
        check({15'h0000, irq_valid}, 16'h0000);
        rd_reg(`ADDR_REQ0H, ACC_BYTE, 16'h0004);
        wr_reg(`ADDR_REQ0H, ACC_BYTE, 3'h0, 16'h0000);
        rd_reg(`ADDR_REQ0H, ACC_BYTE, 16'h0000);
        $display("done: request, mask and priority");
        // Test input: recorded, never vectored, mask gates standby release only
        src.fire(14'h1000);
        rd_reg(`ADDR_REQ1L, ACC_BYTE, 16'h0080);
        check({15'h0000, stby}, 16'h0000);
        wr_reg(`ADDR_MASK1L, ACC_BIT, 3'h7, 16'h0000);
        @(negedge clk);
        check({15'h0000, stby}, 16'h0001);
        check({15'h0000, irq_valid}, 16'h0000);
        wr_reg(`ADDR_MASK1L, ACC_BYTE, 3'h0, 16'h00FF);
        wr_reg(`ADDR_REQ1L, ACC_BYTE, 3'h0, 16'h0000);
        $display("done: test input");
        // Watchdog flag only lives in interval mode
        wdt_int = 1'b0;
        src.fire(14'h2000);
        rd_reg(`ADDR_REQ0L, ACC_BYTE, 16'h0000);
        wdt_int = 1'b1;
        src.fire(14'h2000);
        rd_reg(`ADDR_REQ0L, ACC_BYTE, 16'h0001);
        wr_reg(`ADDR_REQ0L, ACC_BYTE, 3'h0, 16'h0000);
        // Shared receive / 3-wire flag
        src.fire(14'h0800);
        rd_reg(`ADDR_REQ0H, ACC_BYTE, 16'h0008);
        wr_reg(`ADDR_REQ0H, ACC_BYTE, 3'h0, 16'h0000);
        $display("done: watchdog and shared flag");
        // Every edge code on pin 3: rising then falling
        for (int c = 0; c < 4; c++) begin
            wr_reg(`ADDR_REQ0L, ACC_BYTE, 3'h0, 16'h0000);
            wr_reg(`ADDR_EDGE1, ACC_BYTE, 3'h0, {14'h0000, c[1:0]});
            @(negedge clk);
            pin = 7'h08;
            // The zero write lands on the same edge as the pin event, which must win
            repeat (2) @(negedge clk);
            wr_reg(`ADDR_REQ0L, ACC_BYTE, 3'h0, 16'h0000);
            rd_reg(`ADDR_REQ0L, ACC_BYTE, {11'h000, c == 1 || c == 3, 4'h0});
            wr_reg(`ADDR_REQ0L, ACC_BYTE, 3'h0, 16'h0000);
            @(negedge clk);
            pin = 7'h00;
            repeat (6) @(negedge clk);
            rd_reg(`ADDR_REQ0L, ACC_BYTE, {11'h000, c != 1 && c != 2, 4'h0});
        end
        $display("done: pin edge codes");
        repeat (2) @(negedge clk);
        test_done();
    end
endmodule : tb_interrupt_flag_control_regs
